// ==== rtl/rsc_codec_ctrl.v ====
/*
 Control and status logic of the Reed-Solomon codec: Avalon-MM register
 slave, symbol fetch from peripheral memory or nand byte strobes, status
 capture, write-out of location/magnitude words and shared flags.
 Assumes the Galois-field core, memory and nand datapath share ref_clk.
*/
// The Avalon-MM interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "rsc_map.vh"

module rsc_codec_ctrl (
   input  wire         ref_clk,
   input  wire         rst_n,
   input  wire [17:0]  avs_address,
   input  wire         avs_read,
   input  wire         avs_write,
   input  wire [31:0]  avs_writedata,
   output reg  [31:0]  avs_readdata,
   output reg          avs_waitrequest,
   output reg          mem_rd_req,
   output reg  [10:0]  mem_rd_addr,
   input  wire         mem_rd_ack,
   input  wire [15:0]  mem_rd_data,
   output reg          mem_wr_req,
   output reg  [10:0]  mem_wr_addr,
   output reg  [15:0]  mem_wr_data,
   input  wire         mem_wr_ack,
   input  wire         nf_in_valid,
   input  wire [7:0]   nf_in_byte,
   input  wire         nf_out_valid,
   input  wire [7:0]   nf_out_byte,
   output reg          dec_init,
   output reg          dec_sym_valid,
   output reg  [9:0]   dec_sym,
   output reg          dec_code_end,
   output reg          dec_corr_start,
   output reg          dec_code_mode,
   input  wire         dec_result_valid,
   input  wire         dec_has_errors,
   input  wire         dec_fatal,
   input  wire         corr_part1_done,
   input  wire         corr_done,
   input  wire         corr_fail,
   input  wire [4:0]   corr_pairs,
   input  wire         corr_word_valid,
   input  wire [15:0]  corr_word,
   output reg          corr_word_ready,
   output reg          enc_init,
   output reg          enc_sym_valid,
   output reg  [9:0]   enc_sym,
   output reg          enc_code_mode,
   input  wire [255:0] enc_parity,
   input  wire [9:0]   syn_index,
   input  wire [8:0]   bm_index,
   input  wire [9:0]   csf_index,
   input  wire [4:0]   total_errors,
   output reg          xperip_irq
);

   reg         rst_meta;
   reg         rst_sync;
   reg  [15:0] cf;
   reg  [15:0] next_cf;
   reg  [10:0] eptr;
   reg  [15:0] elen;
   reg  [10:0] dptr;
   reg  [15:0] dlen;
   reg  [15:0] xcf;
   reg         irq_en;
   reg  [2:0]  flags;
   reg  [4:0]  nerr;
   reg         ffail;
   reg         rdy2;
   reg         busy;
   reg         rdy1;
   reg         dfail;
   reg         derr;
   reg         dok;
   reg         awaiting;
   reg         ec_pend;
   reg  [10:0] wr_cnt;
   reg  [15:0] dec_left;
   reg  [15:0] dec_cnt;
   reg  [15:0] enc_left;
   reg  [15:0] enc_cnt;
   reg         fetch_dec;
   reg  [15:0] rd_mux;
   reg  [15:0] rp_val;

   wire [15:0] idx    = avs_address[17:2];
   wire [15:0] wd     = avs_writedata[15:0];
   wire        wr_acc = avs_write & ~avs_waitrequest;
   wire        w_cf   = wr_acc & (idx == `RSC_IDX_CF);
   wire        w_xst  = wr_acc & (idx == `RSC_IDX_XST);

   wire        d_mem  = ~cf[`RSC_CF_DNF];
   wire        d_ten  = cf[`RSC_CF_D10B] & d_mem;
   wire        rd_ok  = mem_rd_req & mem_rd_ack;
   wire        dec_take = cf[`RSC_CF_DENA] &
                          (d_mem ? (rd_ok & fetch_dec) : nf_in_valid);
   wire        enc_take = cf[`RSC_CF_EENA] &
                          (cf[`RSC_CF_ENF] ? nf_out_valid : (rd_ok & ~fetch_dec));
   wire        dec_fin = cf[`RSC_CF_DENA] &
                         ((dec_left == 16'h0000) | (dec_take & (dec_left == 16'h0001)));
   wire        enc_fin = cf[`RSC_CF_EENA] &
                         ((enc_left == 16'h0000) | (enc_take & (enc_left == 16'h0001)));
   wire        dec_want = cf[`RSC_CF_DENA] & d_mem & (dec_left != 16'h0000);
   wire        enc_want = cf[`RSC_CF_EENA] & ~cf[`RSC_CF_ENF] & (enc_left != 16'h0000);

   wire [7:0]  d_byte = ~d_mem ? nf_in_byte :
                        (dec_cnt[0] ? mem_rd_data[7:0] : mem_rd_data[15:8]);
   wire [9:0]  d_val  = d_ten ? mem_rd_data[9:0] : {2'b00, d_byte};
   wire [7:0]  e_byte = cf[`RSC_CF_ENF] ? nf_out_byte :
                        (enc_cnt[0] ? mem_rd_data[7:0] : mem_rd_data[15:8]);
   wire [10:0] d_addr = d_ten ? (dptr + dec_cnt[10:0]) : (dptr + dec_cnt[11:1]);
   wire [10:0] e_addr = eptr + enc_cnt[11:1];

   wire        corr_go  = awaiting & dec_result_valid & dec_has_errors;
   wire        ec_set   = ec_pend & rdy1 & rdy2 & ~mem_wr_req;
   wire [2:0]  flag_set = {ec_set, dec_fin & ~cf[`RSC_CF_D10B], enc_fin};
   wire [15:0] st_word  = {3'b000, nerr, 1'b0, ffail, rdy2, busy, rdy1, dfail, derr, dok};

   // Reset release through two flops
   always @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_sync <= rst_meta;
      end
   end

   // Read port mux and register read mux
   always @* begin
      case (xcf[`RSC_XCF_MUX])
         `RSC_MUX_PARITY: rp_val = enc_parity[{cf[`RSC_CF_SEL], 4'h0} +: 16];
         `RSC_MUX_SYN:    rp_val = {6'h00, syn_index};
         `RSC_MUX_BM:     rp_val = {7'h00, bm_index};
         `RSC_MUX_CSF:    rp_val = {6'h00, csf_index};
         `RSC_MUX_TOTERR: rp_val = {11'h000, total_errors};
         default:         rp_val = 16'h0000;
      endcase
      case (idx)
         `RSC_IDX_ST:     rd_mux = st_word;
         `RSC_IDX_CF:     rd_mux = cf;
         `RSC_IDX_EPTR:   rd_mux = {5'h00, eptr};
         `RSC_IDX_ELEN:   rd_mux = elen;
         `RSC_IDX_DPTR:   rd_mux = {5'h00, dptr};
         `RSC_IDX_DLEN:   rd_mux = dlen;
         `RSC_IDX_RDPORT: rd_mux = rp_val;
         `RSC_IDX_XCF:    rd_mux = xcf;
         `RSC_IDX_XST:    rd_mux = {1'b0, irq_en, 5'h00, flags, 6'h00};
         default:         rd_mux = 16'h0000;
      endcase
   end

   // Hardware self-clears; a software write replaces the word
   always @* begin
      next_cf = cf;
      next_cf[`RSC_CF_DEND] = 1'b0;
      if (dec_take)
         next_cf[`RSC_CF_DSTR] = 1'b0;
      if (dec_fin)
         next_cf[`RSC_CF_DENA] = 1'b0;
      if (enc_take)
         next_cf[`RSC_CF_ESTR] = 1'b0;
      if (enc_fin)
         next_cf[`RSC_CF_EENA] = 1'b0;
      if (w_cf) begin
         next_cf = {2'b00, wd[13:0]};
         if (wd[`RSC_CF_DEND])
            next_cf[`RSC_CF_DENA] = 1'b0;
      end
   end

   // Bus slave: one wait cycle, then the access is taken
   always @(posedge ref_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h00000000;
         cf              <= `RSC_RST_REG;
         eptr            <= `RSC_RST_PTR;
         elen            <= `RSC_RST_REG;
         dptr            <= `RSC_RST_PTR;
         dlen            <= `RSC_RST_REG;
         xcf             <= `RSC_RST_REG;
         irq_en          <= 1'b0;
      end else begin
         avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
         if (avs_read & avs_waitrequest)
            avs_readdata <= {16'h0000, rd_mux};
         cf <= next_cf;
         if (wr_acc & (idx == `RSC_IDX_EPTR))
            eptr <= wd[10:0];
         if (wr_acc & (idx == `RSC_IDX_ELEN))
            elen <= wd;
         if (wr_acc & (idx == `RSC_IDX_DPTR))
            dptr <= wd[10:0];
         if (wr_acc & (idx == `RSC_IDX_DLEN))
            dlen <= wd;
         if (wr_acc & (idx == `RSC_IDX_XCF))
            xcf <= wd;
         if (w_xst)
            irq_en <= wd[`RSC_XST_IRQEN];
      end
   end

   // Shared ready flags: set wins over write-one clear
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_flag
         always @(posedge ref_clk or negedge rst_sync) begin
            if (!rst_sync)
               flags[g] <= 1'b0;
            else
               flags[g] <= flag_set[g] | (flags[g] & ~(w_xst & wd[6 + g]));
         end
      end
   endgenerate

   always @(posedge ref_clk or negedge rst_sync) begin
      if (!rst_sync)
         xperip_irq <= 1'b0;
      else
         xperip_irq <= irq_en & (|flags);
   end

   // Symbol counters, symbol strobes and sequence pulses
   always @(posedge ref_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         dec_left      <= 16'h0000;
         dec_cnt       <= 16'h0000;
         enc_left      <= 16'h0000;
         enc_cnt       <= 16'h0000;
         dec_sym_valid <= 1'b0;
         dec_sym       <= 10'h000;
         enc_sym_valid <= 1'b0;
         enc_sym       <= 10'h000;
         dec_init      <= 1'b0;
         enc_init      <= 1'b0;
         dec_code_end  <= 1'b0;
         dec_code_mode <= 1'b0;
         enc_code_mode <= 1'b0;
      end else begin
         dec_init      <= w_cf & wd[`RSC_CF_DSTR];
         enc_init      <= w_cf & wd[`RSC_CF_ESTR];
         dec_code_end  <= w_cf & wd[`RSC_CF_DEND];
         dec_code_mode <= next_cf[`RSC_CF_DMODE];
         enc_code_mode <= next_cf[`RSC_CF_EMODE];
         dec_sym_valid <= dec_take;
         enc_sym_valid <= enc_take;
         if (dec_take)
            dec_sym <= d_val;
         if (enc_take)
            enc_sym <= {2'b00, e_byte};
         if (w_cf & wd[`RSC_CF_DENA] & ~cf[`RSC_CF_DENA]) begin
            dec_left <= dlen;
            dec_cnt  <= 16'h0000;
         end else if (dec_take) begin
            dec_left <= dec_left - 16'h0001;
            dec_cnt  <= dec_cnt + 16'h0001;
         end
         if (w_cf & wd[`RSC_CF_EENA] & ~cf[`RSC_CF_EENA]) begin
            enc_left <= elen;
            enc_cnt  <= 16'h0000;
         end else if (enc_take) begin
            enc_left <= enc_left - 16'h0001;
            enc_cnt  <= enc_cnt + 16'h0001;
         end
      end
   end

   // Memory fetch: one outstanding read, decoder first
   always @(posedge ref_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         mem_rd_req  <= 1'b0;
         mem_rd_addr <= `RSC_RST_PTR;
         fetch_dec   <= 1'b0;
      end else if (mem_rd_req) begin
         if (mem_rd_ack)
            mem_rd_req <= 1'b0;
      end else if (dec_want) begin
         mem_rd_req  <= 1'b1;
         mem_rd_addr <= d_addr;
         fetch_dec   <= 1'b1;
      end else if (enc_want) begin
         mem_rd_req  <= 1'b1;
         mem_rd_addr <= e_addr;
         fetch_dec   <= 1'b0;
      end
   end

   // Decode result and correction progress
   always @(posedge ref_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         awaiting       <= 1'b0;
         dok            <= 1'b0;
         derr           <= 1'b0;
         dfail          <= 1'b0;
         rdy1           <= 1'b0;
         rdy2           <= 1'b0;
         busy           <= 1'b0;
         ffail          <= 1'b0;
         nerr           <= 5'h00;
         ec_pend        <= 1'b0;
         dec_corr_start <= 1'b0;
      end else begin
         dec_corr_start <= corr_go;
         if (w_cf & wd[`RSC_CF_DSTR]) begin
            awaiting <= 1'b0;
            dok      <= 1'b0;
            derr     <= 1'b0;
            dfail    <= 1'b0;
            rdy1     <= 1'b0;
            rdy2     <= 1'b0;
            busy     <= 1'b0;
            ffail    <= 1'b0;
            nerr     <= 5'h00;
            ec_pend  <= 1'b0;
         end else begin
            if (w_cf & wd[`RSC_CF_DEND])
               awaiting <= 1'b1;
            else if (dec_result_valid)
               awaiting <= 1'b0;
            if (awaiting & dec_result_valid) begin
               dfail <= dec_fatal;
               derr  <= dec_has_errors;
               dok   <= ~dec_has_errors & ~dec_fatal;
            end
            if (corr_go) begin
               busy    <= 1'b1;
               rdy1    <= 1'b0;
               rdy2    <= 1'b0;
               ffail   <= 1'b0;
               ec_pend <= 1'b0;
            end else begin
               if (corr_part1_done)
                  rdy1 <= 1'b1;
               if (corr_done) begin
                  rdy2    <= 1'b1;
                  busy    <= 1'b0;
                  ffail   <= corr_fail;
                  nerr    <= corr_pairs;
                  ec_pend <= 1'b1;
               end else if (ec_set)
                  ec_pend <= 1'b0;
            end
         end
      end
   end

   // Location/magnitude words go out from the decoder pointer upward
   always @(posedge ref_clk or negedge rst_sync) begin
      if (!rst_sync) begin
         mem_wr_req      <= 1'b0;
         mem_wr_addr     <= `RSC_RST_PTR;
         mem_wr_data     <= 16'h0000;
         corr_word_ready <= 1'b1;
         wr_cnt          <= 11'h000;
      end else begin
         if (corr_go)
            wr_cnt <= 11'h000;
         else if (corr_word_valid & corr_word_ready) begin
            mem_wr_req      <= 1'b1;
            mem_wr_addr     <= dptr + wr_cnt;
            mem_wr_data     <= corr_word;
            corr_word_ready <= 1'b0;
            wr_cnt          <= wr_cnt + 11'h001;
         end else if (mem_wr_req & mem_wr_ack) begin
            mem_wr_req      <= 1'b0;
            corr_word_ready <= 1'b1;
         end
      end
   end

endmodule // rsc_codec_ctrl

// ==== rtl/rsc_map.vh ====
/*
 Register indices, field positions, mux codes and reset values of the
 Reed-Solomon codec control block. Definitions only.
 Assumes byte address = 4 x register index on a 32-bit bus.
*/
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

`define RSC_IDX_ST      16'hFC70
`define RSC_IDX_CF      16'hFC71
`define RSC_IDX_EPTR    16'hFC72
`define RSC_IDX_ELEN    16'hFC73
`define RSC_IDX_DPTR    16'hFC74
`define RSC_IDX_DLEN    16'hFC75
`define RSC_IDX_RDPORT  16'hFC76
`define RSC_IDX_XCF     16'hFC6E
`define RSC_IDX_XST     16'hFC6F

`define RSC_RST_REG     16'h0000
`define RSC_RST_PTR     11'h000

`define RSC_ST_NERR     12:8
`define RSC_ST_FFAIL    6
`define RSC_ST_RDY2     5
`define RSC_ST_BUSY     4
`define RSC_ST_RDY1     3
`define RSC_ST_DFAIL    2
`define RSC_ST_DERR     1
`define RSC_ST_DOK      0

`define RSC_CF_DNF      13
`define RSC_CF_D10B     12
`define RSC_CF_DEND     11
`define RSC_CF_DSTR     10
`define RSC_CF_DENA     9
`define RSC_CF_DMODE    8
`define RSC_CF_SEL      7:4
`define RSC_CF_ENF      3
`define RSC_CF_ESTR     2
`define RSC_CF_EENA     1
`define RSC_CF_EMODE    0

`define RSC_XST_IRQEN   14
`define RSC_XST_FLAGS   8:6
`define RSC_XCF_MUX     15:12

`define RSC_MUX_PARITY  4'h0
`define RSC_MUX_SYN     4'h1
`define RSC_MUX_BM      4'h2
`define RSC_MUX_CSF     4'h3
`define RSC_MUX_TOTERR  4'hB

`endif

// ==== verification/rsc_codec_ctrl_chk.sv ====
/* Port checker of the codec control block.
   Assumes one clock; bound to rsc_codec_ctrl below. */
`timescale 1ns/1ns
`include "rsc_map.vh"
module rsc_codec_ctrl_chk (
   input wire logic        ref_clk,
   input wire logic        rst_n,
   input wire logic [17:0] avs_address,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic        avs_waitrequest,
   input wire logic        mem_rd_req,
   input wire logic [10:0] mem_rd_addr,
   input wire logic        mem_rd_ack,
   input wire logic        mem_wr_req,
   input wire logic [10:0] mem_wr_addr,
   input wire logic [15:0] mem_wr_data,
   input wire logic        mem_wr_ack,
   input wire logic        corr_word_ready,
   input wire logic        dec_init,
   input wire logic        enc_init,
   input wire logic        dec_code_end,
   input wire logic        dec_corr_start,
   input wire logic        dec_result_valid,
   input wire logic        dec_has_errors,
   input wire logic        dec_sym_valid,
   input wire logic        enc_sym_valid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   wire cf_wr = avs_write && !avs_waitrequest && avs_address[17:2] == `RSC_IDX_CF;
   dec_start_a: assert property (cf_wr && avs_writedata[10] |=> dec_init ##1 !dec_init)
      else $error("decoder init pulse wrong");
   code_end_a: assert property (cf_wr && avs_writedata[11] |=> dec_code_end ##1 !dec_code_end)
      else $error("code end pulse wrong");
   enc_start_a: assert property (cf_wr && avs_writedata[2] |=> enc_init)
      else $error("encoder init missing");
   corr_auto_a: assert property (dec_result_valid && dec_has_errors |=> dec_corr_start)
      else $error("correction not started");
   fetch_hold_a: assert property (mem_rd_req && !mem_rd_ack |=> mem_rd_req && $stable(mem_rd_addr))
      else $error("fetch request dropped");
   fetch_sym_a: assert property (mem_rd_req && mem_rd_ack |=> (dec_sym_valid || enc_sym_valid) && !mem_rd_req)
      else $error("fetched word gave no symbol");
   pair_hold_a: assert property (mem_wr_req && !mem_wr_ack |=> mem_wr_req && $stable({mem_wr_addr, mem_wr_data}))
      else $error("pair write not held");
   pair_block_a: assert property (mem_wr_req |-> !corr_word_ready)
      else $error("pair taken while write pending");
   cover property (cf_wr && avs_writedata[11]);
   cover property (mem_wr_req && mem_wr_ack);
   cover property (enc_sym_valid);
endmodule // rsc_codec_ctrl_chk

bind rsc_codec_ctrl rsc_codec_ctrl_chk chk_i (.ref_clk, .rst_n, .avs_address, .avs_write,
   .avs_writedata, .avs_waitrequest, .mem_rd_req, .mem_rd_addr, .mem_rd_ack, .mem_wr_req,
   .mem_wr_addr, .mem_wr_data, .mem_wr_ack, .corr_word_ready, .dec_init, .enc_init,
   .dec_code_end, .dec_corr_start, .dec_result_valid, .dec_has_errors, .dec_sym_valid,
   .enc_sym_valid);

// ==== verification/rsc_mem_model.sv ====
/* Peripheral memory model: word reads and writes, one-cycle ack after a
   varying wait. Assumes requests are held until acknowledged. */
`timescale 1ns/1ns
module rsc_mem_model (
   input  wire logic        ref_clk,
   input  wire logic        mem_rd_req,
   input  wire logic [10:0] mem_rd_addr,
   output logic             mem_rd_ack,
   output logic [15:0]      mem_rd_data,
   input  wire logic        mem_wr_req,
   input  wire logic [10:0] mem_wr_addr,
   input  wire logic [15:0] mem_wr_data,
   output logic             mem_wr_ack
);
   logic [15:0] mem [0:2047];
   logic [15:0] wr_log [$];
   logic [10:0] wa_log [$];
   logic [7:0]  lf = 8'hA5;
   int          rd_wait = 0;
   int          wr_wait = 2;
   initial begin
      {mem_rd_ack, mem_wr_ack, mem_rd_data} = '0;
      for (int a = 0; a < 2048; a++)
         mem[a] = 16'(a * 40503) ^ 16'h5A5A;
   end
   always @(posedge ref_clk) begin
      lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      mem_rd_ack <= 1'b0;
      mem_wr_ack <= 1'b0;
      // Idle bus toggles so no stale word can pass for data
      mem_rd_data <= ~mem_rd_data;
      if (mem_rd_req && !mem_rd_ack) begin
         rd_wait <= (rd_wait == 0) ? int'(lf[2:0]) : rd_wait - 1;
         if (rd_wait == 0) begin
            mem_rd_ack <= 1'b1;
            mem_rd_data <= mem[mem_rd_addr];
         end
      end
      if (mem_wr_req && !mem_wr_ack) begin
         wr_wait <= (wr_wait == 0) ? int'(lf[4:3]) : wr_wait - 1;
         if (wr_wait == 0) begin
            mem_wr_ack <= 1'b1;
            mem[mem_wr_addr] <= mem_wr_data;
            wr_log.push_back(mem_wr_data);
            wa_log.push_back(mem_wr_addr);
         end
      end
   end
endmodule // rsc_mem_model

// ==== verification/test_rsc_codec_ctrl.sv ====
/* Self-checking bench of the codec control block with memory model.
   Assumes the core and nand strobes are played by the bench. */
`timescale 1ns/1ns
`include "rsc_map.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
   $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_rsc_codec_ctrl;
   logic         ref_clk, rst_n, avs_read, avs_write, mem_rd_ack, mem_wr_ack, xperip_irq;
   logic         nf_in_valid, nf_out_valid, dec_result_valid, dec_has_errors, dec_fatal;
   logic         corr_part1_done, corr_done, corr_fail, corr_word_valid, corr_word_ready;
   logic         avs_waitrequest, mem_rd_req, mem_wr_req, dec_init, dec_sym_valid;
   logic         dec_code_end, dec_corr_start, dec_code_mode, enc_init;
   logic         enc_sym_valid, enc_code_mode;
   logic [17:0]  avs_address;
   logic [31:0]  avs_writedata, avs_readdata;
   logic [10:0]  mem_rd_addr, mem_wr_addr;
   logic [15:0]  mem_rd_data, mem_wr_data, corr_word, rd, e;
   logic [15:0]  cw [2];
   logic [7:0]   nf_in_byte, nf_out_byte;
   logic [9:0]   dec_sym, enc_sym, syn_index, csf_index;
   logic [8:0]   bm_index;
   logic [4:0]   corr_pairs, total_errors;
   logic [3:0]   s;
   logic [3:0]   codes [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hB, 4'h7};
   logic [255:0] enc_parity;
   logic [31:0]  seed = 32'h8A3E3A89;
   logic [9:0]   dq [$], eq [$];
   int           n_errors = 0, checks_done = 0, i, n;

   rsc_codec_ctrl DUT (.*);
   rsc_mem_model mdl (.*);

   // Symbol monitor: every strobe the core sees lands in the bench queues dq and eq
   always @(posedge ref_clk) begin
      if (dec_sym_valid === 1'b1)
         dq.push_back(dec_sym);
      if (enc_sym_valid === 1'b1)
         eq.push_back(enc_sym);
   end

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic report_and_stop;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic bus(input logic w, input logic [15:0] a, d, output logic [15:0] q);
      int k;
      k = 0;
      @(posedge ref_clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= {a, 2'b00};
      avs_writedata <= {16'h0000, d};
      do begin
         @(posedge ref_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 50);
      if (avs_waitrequest !== 1'b0)
         n_errors++;
      q = avs_readdata[15:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, d);
      bus(1'b1, a, d, rd);
   endtask
   task automatic rchk(input logic [15:0] a, x);
      bus(1'b0, a, 16'h0000, rd);
      `CHK(rd, x)
   endtask
   task automatic result(input logic f, h);
      @(posedge ref_clk);
      dec_result_valid <= 1'b1;
      dec_fatal <= f;
      dec_has_errors <= h;
      @(posedge ref_clk);
      dec_result_valid <= 1'b0;
   endtask

   task automatic op(input logic enc, input logic [15:0] cf, input int len, input logic ten);
      logic [15:0] w;
      logic [10:0] p;
      logic [9:0]  x [$];
      int          k;
      void'(rnd());
      p = {1'b0, seed[9:0]};
      dq.delete();
      eq.delete();
      wr(enc ? `RSC_IDX_EPTR : `RSC_IDX_DPTR, {5'h00, p});
      wr(enc ? `RSC_IDX_ELEN : `RSC_IDX_DLEN, len[15:0]);
      wr(`RSC_IDX_CF, cf);
      for (k = 0; k < len; k++) begin
         w = mdl.mem[p + (ten ? k : k / 2)];
         if (cf[13] | cf[3]) begin
            void'(rnd());
            w = {seed[7:0], seed[7:0]};
            @(posedge ref_clk);
            nf_in_valid <= !enc;
            nf_out_valid <= enc;
            nf_in_byte <= w[7:0];
            nf_out_byte <= w[7:0];
            @(posedge ref_clk);
            nf_in_valid <= 1'b0;
            nf_out_valid <= 1'b0;
         end
         x.push_back(ten ? w[9:0] : {2'b00, k[0] ? w[7:0] : w[15:8]});
      end
      k = 0;
      do begin
         bus(1'b0, `RSC_IDX_CF, 16'h0000, rd);
         k++;
      end while (rd[enc ? 1 : 9] !== 1'b0 && k < 100);
      `CHK(enc ? eq.size() : dq.size(), len)
      for (k = 0; k < len; k++)
         `CHK(enc ? eq[k] : dq[k], x[k])
      rchk(`RSC_IDX_CF, cf & 16'hF9F9);
      rchk(`RSC_IDX_XST, ten ? 16'h0000 : (enc ? 16'h0040 : 16'h0080));
      `CHK({enc_code_mode, dec_code_mode}, {cf[0], cf[8]})
      wr(`RSC_IDX_XST, 16'h01C0);
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end
   initial begin
      #200000;
      n_errors++;
      report_and_stop();
   end

   initial begin
      {rst_n, avs_read, avs_write, nf_in_valid, nf_out_valid, dec_result_valid} = '0;
      {dec_has_errors, dec_fatal, corr_part1_done, corr_done, corr_fail, corr_word_valid} = '0;
      {avs_address, avs_writedata, nf_in_byte, nf_out_byte, corr_pairs, corr_word} = '0;
      for (i = 0; i < 8; i++)
         enc_parity[32*i +: 32] = rnd();
      syn_index = seed[9:0];
      bm_index = seed[18:10];
      csf_index = seed[28:19];
      total_errors = seed[31:27];
      repeat (10) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      for (i = 0; i < 7; i++)
         rchk(16'hFC70 + i[15:0], i == 6 ? enc_parity[15:0] : 16'h0000);
      for (i = 2; i < 6; i++) begin
         void'(rnd());
         e = seed[15:0] & 16'h07FF;
         wr(16'hFC70 + i[15:0], e);
         rchk(16'hFC70 + i[15:0], e);
      end
      wr(`RSC_IDX_ST, 16'hFFFF);
      rchk(`RSC_IDX_ST, 16'h0000);
      wr(16'hFC40, 16'hFFFF);
      rchk(16'hFC40, 16'h0000);
      op(1'b0, 16'h0600, 5, 1'b0);
      op(1'b0, 16'h1700, 3, 1'b1);
      op(1'b1, 16'h0006, 4, 1'b0);
      op(1'b0, 16'h2600, 2, 1'b0);
      op(1'b1, 16'h000F, 3, 1'b0);
      wr(`RSC_IDX_DPTR, 16'h0123);
      wr(`RSC_IDX_CF, 16'h0800);
      rchk(`RSC_IDX_CF, 16'h0000);
      result(1'b0, 1'b1);
      rchk(`RSC_IDX_ST, 16'h0012);
      @(posedge ref_clk);
      corr_part1_done <= 1'b1;
      @(posedge ref_clk);
      corr_part1_done <= 1'b0;
      rchk(`RSC_IDX_ST, 16'h001A);
      for (i = 0; i < 2; i++) begin
         void'(rnd());
         cw[i] = seed[15:0];
         @(posedge ref_clk);
         corr_word_valid <= 1'b1;
         corr_word <= cw[i];
         n = 0;
         do begin
            @(posedge ref_clk);
            n++;
         end while (corr_word_ready !== 1'b1 && n < 50);
         if (corr_word_ready !== 1'b1)
            n_errors++;
         corr_word_valid <= 1'b0;
      end
      n = 0;
      while (mdl.wr_log.size() < 2 && n++ < 50)
         @(posedge ref_clk);
      `CHK(mdl.wr_log.size(), 2)
      @(posedge ref_clk);
      {corr_done, corr_fail, corr_pairs} <= {2'b11, 5'h13};
      @(posedge ref_clk);
      corr_done <= 1'b0;
      rchk(`RSC_IDX_ST, 16'h136A);
      rchk(`RSC_IDX_XST, 16'h0100);
      rchk(`RSC_IDX_DPTR, 16'h0123);
      for (i = 0; i < 2; i++) begin
         `CHK(mdl.wa_log[i], 11'h123 + i[10:0])
         `CHK(mdl.wr_log[i], cw[i])
      end
      `CHK(xperip_irq, 1'b0)
      wr(`RSC_IDX_XST, 16'h4000);
      repeat (2) @(posedge ref_clk);
      `CHK(xperip_irq, 1'b1)
      wr(`RSC_IDX_XST, 16'h4100);
      repeat (2) @(posedge ref_clk);
      `CHK(xperip_irq, 1'b0)
      rchk(`RSC_IDX_XST, 16'h4000);
      wr(`RSC_IDX_XST, 16'h0000);
      for (i = 0; i < 2; i++) begin
         wr(`RSC_IDX_CF, 16'h0400);
         result(i == 0, 1'b0);
         rchk(`RSC_IDX_ST, 16'h0000);
         wr(`RSC_IDX_CF, 16'h0800);
         result(i == 0, 1'b0);
         rchk(`RSC_IDX_ST, i == 0 ? 16'h0004 : 16'h0001);
      end
      for (i = 0; i < 6; i++) begin
         void'(rnd());
         s = seed[3:0];
         wr(`RSC_IDX_XCF, {codes[i], 12'h000});
         wr(`RSC_IDX_CF, {8'h00, s, 4'h0});
         case (codes[i])
            4'h0: e = enc_parity[16*s +: 16];
            4'h1: e = {6'h00, syn_index};
            4'h2: e = {7'h00, bm_index};
            4'h3: e = {6'h00, csf_index};
            4'hB: e = {11'h000, total_errors};
            default: e = 16'h0000;
         endcase
         rchk(`RSC_IDX_RDPORT, e);
      end
      report_and_stop();
   end
endmodule // test_rsc_codec_ctrl
